// *** rtl/csel_top.sv ***
// control interface select: hardware, serial or parallel register access
`timescale 1ns/1ns
module csel_top
  import csel_pkg::*;
#(
  parameter int NPORT = 4,
  parameter int HW_W  = 16
)(
  input  wire logic                    core_clk_i,
  input  wire logic                    sys_rst_i,
  input  wire logic [SEL_W-1:0]        interface_select_i,
  input  wire logic                    force_tristate_in_i,
  input  wire logic                    par_muxed_i,
  input  wire csel_par_ctl_type        par_ctl_i,
  input  wire logic [REG_ADDR_W-1:0]   par_addr_i,
  input  wire logic [DATA_W-1:0]       par_data_i,
  output logic [DATA_W-1:0]            par_data_o,
  output logic [1:0]                   par_data_oe_n_o,
  input  wire csel_spi_pins_type       spi_pins_i,
  input  wire logic                    spi_cpol_i,
  input  wire logic                    spi_cpha_i,
  output logic                         spi_sdo_o,
  output logic                         spi_sdo_oe_n_o,
  input  wire logic [HW_W-1:0]         hw_ctrl_i,
  output logic [HW_W-1:0]              hw_ctrl_o,
  input  wire logic [NPORT-1:0]        port_los_i,
  output logic [NPORT-1:0]             port_loss_of_signal_out_o,
  output logic [NPORT-1:0]             port_los_oe_n_o,
  output csel_mode_type                mode_o,
  output csel_reg_req_type             reg_req_o,
  input  wire logic [DATA_W-1:0]       reg_rdata_i
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int PIN_W = SEL_W + 1 + 1 + $bits(csel_par_ctl_type)
                       + REG_ADDR_W + DATA_W
                       + $bits(csel_spi_pins_type) + HW_W;

  logic [PIN_W-1:0]        pin_a_ff;
  logic [PIN_W-1:0]        pin_b_ff;
  logic [SEL_W-1:0]        sel_s;
  logic                    force_s;
  logic                    muxed_raw;
  csel_par_ctl_type        par_raw;
  logic [REG_ADDR_W-1:0]   addr_raw;
  logic [DATA_W-1:0]       data_raw;
  csel_spi_pins_type       spi_raw;
  logic [HW_W-1:0]         hw_raw;

  // all pins come from outside the clock domain; only stage b is read
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pin_a_ff <= '0;
      pin_b_ff <= '0;
    end else begin
      pin_a_ff <= {interface_select_i, force_tristate_in_i, par_muxed_i,
                   par_ctl_i, par_addr_i, par_data_i, spi_pins_i,
                   hw_ctrl_i};
      pin_b_ff <= pin_a_ff;
    end
  end

  assign {sel_s, force_s, muxed_raw, par_raw, addr_raw, data_raw,
          spi_raw, hw_raw} = pin_b_ff;

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  csel_mode_type mode_ff;
  logic          style_ff;
  logic          force_ff;
  logic          hw_mode;
  logic          spi_mode;
  logic          par_mode;
  logic          par16_mode;

  // select is a static strap; decoding it every cycle only costs a few
  // gates and keeps reset free of any port value
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      mode_ff  <= IFM_HW;
      style_ff <= 1'b0;
      force_ff <= 1'b0;
    end else begin
      case (sel_s[SEL_W-1:SEL_MODE_LSB])
        SEL_HW:    mode_ff <= IFM_HW;
        SEL_SPI:   mode_ff <= IFM_SPI;
        SEL_PAR8:  mode_ff <= IFM_PAR8;
        SEL_PAR16: mode_ff <= IFM_PAR16;
        default:   mode_ff <= IFM_HW;
      endcase
      style_ff <= sel_s[SEL_STYLE_BIT];
      force_ff <= force_s;
    end
  end

  assign hw_mode    = (mode_ff == IFM_HW);
  assign spi_mode   = (mode_ff == IFM_SPI);
  assign par16_mode = (mode_ff == IFM_PAR16);
  assign par_mode   = (mode_ff == IFM_PAR8) || par16_mode;

  // ----------------------------------------------------------------
  // input gating: pins of unselected interfaces read as low
  // ----------------------------------------------------------------
  csel_par_ctl_type       par_s;
  csel_spi_pins_type      spi_s;
  logic [DATA_W-1:0]      data_s;
  logic [REG_ADDR_W-1:0]  addr_s;
  logic                   muxed_s;
  logic [HW_W-1:0]        hw_s;

  always_comb begin
    par_s   = par_mode ? par_raw : '0;
    spi_s   = spi_mode ? spi_raw : '0;
    data_s  = par_mode ? data_raw : '0;
    addr_s  = par_mode ? addr_raw : '0;
    muxed_s = par_mode & muxed_raw;
    hw_s    = hw_mode ? hw_raw : '0;
    if (!par16_mode) begin
      data_s[DATA_W-1:BYTE_W] = '0;
    end
    if (style_ff) begin
      par_s.rd_n = 1'b0;
      par_s.wr_n = 1'b0;
    end else begin
      par_s.rw            = 1'b0;
      par_s.data_strobe_n = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // parallel bus access
  // ----------------------------------------------------------------
  typedef enum {PAR_IDLE, PAR_RD, PAR_WR} csel_par_state_type;

  csel_par_state_type     par_state_ff;
  logic [REG_ADDR_W-1:0]  addr_lat_ff;
  logic [DATA_W-1:0]      wdata_cap_ff;
  csel_reg_req_type       par_req_ff;
  logic                   par_acc;
  logic                   par_is_rd;

  always_comb begin
    if (style_ff) begin
      par_acc   = ~par_s.cs_n & ~par_s.data_strobe_n;
      par_is_rd = par_s.rw;
    end else begin
      par_acc   = ~par_s.cs_n & (~par_s.rd_n | ~par_s.wr_n);
      par_is_rd = ~par_s.rd_n;
    end
    par_acc = par_acc & par_mode;
  end

  // multiplexed bus: address rides the data lines while ale is high
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      addr_lat_ff <= '0;
    end else if (muxed_s && par_s.ale) begin
      addr_lat_ff <= data_s[REG_ADDR_W-1:0];
    end
  end

  // writes commit on strobe release so that the data are settled
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      par_state_ff <= PAR_IDLE;
      wdata_cap_ff <= '0;
      par_req_ff   <= '0;
    end else begin
      par_req_ff.req <= 1'b0;
      case (par_state_ff)
        PAR_IDLE: begin
          if (par_acc) begin
            par_req_ff.addr <= muxed_s ? addr_lat_ff : addr_s;
            par_req_ff.wide <= par16_mode;
            if (par_is_rd) begin
              par_req_ff.req <= 1'b1;
              par_req_ff.we  <= 1'b0;
              par_state_ff   <= PAR_RD;
            end else begin
              wdata_cap_ff <= data_s;
              par_state_ff <= PAR_WR;
            end
          end
        end
        PAR_RD: begin
          if (!par_acc) begin
            par_state_ff <= PAR_IDLE;
          end
        end
        PAR_WR: begin
          if (par_acc) begin
            wdata_cap_ff <= data_s;
          end else begin
            par_req_ff.req   <= 1'b1;
            par_req_ff.we    <= 1'b1;
            par_req_ff.wdata <= wdata_cap_ff;
            par_state_ff     <= PAR_IDLE;
          end
        end
        default: par_state_ff <= PAR_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // serial engine
  // ----------------------------------------------------------------
  csel_reg_req_type  spi_req;
  logic              spi_sdo;
  logic              spi_sdo_oe_n;
  logic [DATA_W-1:0] rdata_ff;
  logic              rdata_vld_ff;

  // host keeps the bit rate at or below SPI_MAX_BPS, so each serial
  // half period spans at least two clocks after synchronising
  csel_spi_engine u_spi (
    .core_clk_i  (core_clk_i),
    .sys_rst_i   (sys_rst_i),
    .en_i        (spi_mode),
    .sclk_i      (spi_s.sclk),
    .cs_n_i      (spi_s.cs_n),
    .sdi_i       (spi_s.sdi),
    .cpol_i      (spi_cpol_i),
    .cpha_i      (spi_cpha_i),
    .rdata_vld_i (rdata_vld_ff),
    .rdata_i     (rdata_ff[BYTE_W-1:0]),
    .req_o       (spi_req),
    .sdo_o       (spi_sdo),
    .sdo_oe_n_o  (spi_sdo_oe_n)
  );

  // ----------------------------------------------------------------
  // register access port toward the internal register file
  // ----------------------------------------------------------------
  csel_reg_req_type reg_req_ff;
  logic             rd_pend_ff;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      reg_req_ff <= '0;
    end else if (spi_mode) begin
      reg_req_ff <= spi_req;
    end else if (par_mode) begin
      reg_req_ff <= par_req_ff;
    end else begin
      reg_req_ff <= '0;
    end
  end

  // read data are valid the cycle after the request pulse
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rd_pend_ff   <= 1'b0;
      rdata_ff     <= '0;
      rdata_vld_ff <= 1'b0;
    end else begin
      rd_pend_ff   <= reg_req_ff.req & ~reg_req_ff.we;
      rdata_vld_ff <= rd_pend_ff;
      if (rd_pend_ff) begin
        rdata_ff <= reg_rdata_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // output pins
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] par_data_ff;
  logic [1:0]        par_data_oe_n_ff;
  logic              par_drive;
  logic              spi_sdo_ff;
  logic              spi_sdo_oe_n_ff;

  // upper byte floats in 8-bit mode; read data held until next read
  assign par_drive = par_mode && par_state_ff == PAR_RD && par_acc;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      par_data_ff      <= '0;
      par_data_oe_n_ff <= {OE_N_OFF, OE_N_OFF};
    end else begin
      if (rdata_vld_ff && par_mode) begin
        par_data_ff <= rdata_ff;
      end
      par_data_oe_n_ff[0] <= force_ff | ~par_drive;
      par_data_oe_n_ff[1] <= force_ff | ~par_drive
                             | ~par16_mode;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      spi_sdo_ff      <= 1'b0;
      spi_sdo_oe_n_ff <= OE_N_OFF;
    end else begin
      spi_sdo_ff      <= spi_sdo;
      spi_sdo_oe_n_ff <= force_ff | ~spi_mode | spi_sdo_oe_n;
    end
  end

  // ----------------------------------------------------------------
  // hardware control pins and per-port status
  // ----------------------------------------------------------------
  logic [HW_W-1:0]  hw_ctrl_ff;
  logic [NPORT-1:0] los_ff;
  logic [NPORT-1:0] los_oe_n_ff;
  csel_mode_type    mode_out_ff;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      hw_ctrl_ff  <= '0;
      mode_out_ff <= IFM_HW;
    end else begin
      hw_ctrl_ff  <= hw_s;
      mode_out_ff <= mode_ff;
    end
  end

  generate
    for (genvar p = 0; p < NPORT; p++) begin : g_los
      always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
          los_ff[p]      <= 1'b0;
          los_oe_n_ff[p] <= OE_N_OFF;
        end else begin
          los_ff[p]      <= port_los_i[p];
          los_oe_n_ff[p] <= force_ff;
        end
      end
    end
  endgenerate

  assign par_data_o                = par_data_ff;
  assign par_data_oe_n_o           = par_data_oe_n_ff;
  assign spi_sdo_o                 = spi_sdo_ff;
  assign spi_sdo_oe_n_o            = spi_sdo_oe_n_ff;
  assign hw_ctrl_o                 = hw_ctrl_ff;
  assign port_loss_of_signal_out_o = los_ff;
  assign port_los_oe_n_o           = los_oe_n_ff;
  assign mode_o                    = mode_out_ff;
  assign reg_req_o                 = reg_req_ff;

endmodule : csel_top

// *** rtl/csel_pkg.sv ***
// constants, modes and carrier types for the control interface select block
package csel_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int SEL_W      = 3;
  localparam int DATA_W     = 16;
  localparam int BYTE_W     = 8;
  localparam int REG_ADDR_W = 8;
  localparam int SPI_ADDR_W = 7;
  localparam int BIT_CNT_W  = 3;

  // ----------------------------------------------------------------
  // select codes on interface_select[2:1], style on bit 0
  // ----------------------------------------------------------------
  localparam logic [1:0] SEL_HW    = 2'h0;
  localparam logic [1:0] SEL_SPI   = 2'h1;
  localparam logic [1:0] SEL_PAR8  = 2'h2;
  localparam logic [1:0] SEL_PAR16 = 2'h3;
  localparam int         SEL_STYLE_BIT = 0;
  localparam int         SEL_MODE_LSB  = 1;

  // ----------------------------------------------------------------
  // serial command byte layout and timing
  // ----------------------------------------------------------------
  localparam int SPI_RD_BIT   = 7;
  localparam int SPI_BYTE_MSB = 7;
  localparam logic [BIT_CNT_W-1:0] SPI_LAST_BIT = 3'h7;
  localparam longint CLK_HZ      = 50_000_000;
  localparam longint SPI_MAX_BPS = 10_000_000;
  // least clock cycles per serial bit at the top rate, rounded up
  localparam int SPI_MIN_BIT_CYC =
    int'((CLK_HZ + SPI_MAX_BPS - 1) / SPI_MAX_BPS);

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic OE_N_OFF = 1'b1;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    IFM_HW, IFM_SPI, IFM_PAR8, IFM_PAR16
  } csel_mode_type;

  typedef struct packed {
    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic rw;
    logic data_strobe_n;
    logic ale;
  } csel_par_ctl_type;

  typedef struct packed {
    logic sclk;
    logic cs_n;
    logic sdi;
  } csel_spi_pins_type;

  typedef struct packed {
    logic                  req;
    logic                  we;
    logic                  wide;
    logic [REG_ADDR_W-1:0] addr;
    logic [DATA_W-1:0]     wdata;
  } csel_reg_req_type;

endpackage : csel_pkg

// *** rtl/csel_spi_engine.sv ***
// serial register access engine, bytes with burst address increment
`timescale 1ns/1ns
module csel_spi_engine
  import csel_pkg::*;
(
  input  wire logic             core_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             en_i,
  input  wire logic             sclk_i,
  input  wire logic             cs_n_i,
  input  wire logic             sdi_i,
  input  wire logic             cpol_i,
  input  wire logic             cpha_i,
  input  wire logic             rdata_vld_i,
  input  wire logic [BYTE_W-1:0] rdata_i,
  output csel_reg_req_type      req_o,
  output logic                  sdo_o,
  output logic                  sdo_oe_n_o
);

  typedef enum {SPI_CMD, SPI_WR, SPI_RD} csel_spi_state_type;

  csel_spi_state_type     state_ff;
  logic                   sclk_x_ff;
  logic [BIT_CNT_W-1:0]   bit_cnt_ff;
  logic [BYTE_W-1:0]      sh_ff;
  logic [SPI_ADDR_W-1:0]  addr_ff;
  logic [BYTE_W-1:0]      rd_byte_ff;
  csel_reg_req_type       req_ff;
  logic                   sdo_ff;
  logic                   sdo_oe_n_ff;
  logic                   active;
  logic                   sclk_x;
  logic                   samp;
  logic [BYTE_W-1:0]      nxt_byte;
  logic [SPI_ADDR_W-1:0]  nxt_addr;

  assign active   = en_i & ~cs_n_i;
  assign sclk_x   = sclk_i ^ cpol_i;
  // leading edge samples for phase 0, trailing edge for phase 1
  assign samp     = cpha_i ? (~sclk_x & sclk_x_ff)
                           : (sclk_x & ~sclk_x_ff);
  assign nxt_byte = {sh_ff[BYTE_W-2:0], sdi_i};
  assign nxt_addr = addr_ff + 1'b1;

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      sclk_x_ff <= 1'b0;
    end else begin
      sclk_x_ff <= sclk_x;
    end
  end

  // ----------------------------------------------------------------
  // byte assembly and register requests
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || !active) begin
      state_ff   <= SPI_CMD;
      bit_cnt_ff <= '0;
      sh_ff      <= '0;
      addr_ff    <= '0;
      req_ff     <= '0;
    end else begin
      req_ff.req <= 1'b0;
      if (samp) begin
        sh_ff      <= nxt_byte;
        bit_cnt_ff <= bit_cnt_ff + 1'b1;
        if (bit_cnt_ff == SPI_LAST_BIT) begin
          case (state_ff)
            SPI_CMD: begin
              addr_ff     <= nxt_byte[SPI_ADDR_W-1:0];
              req_ff.addr <= REG_ADDR_W'(nxt_byte[SPI_ADDR_W-1:0]);
              req_ff.we   <= 1'b0;
              req_ff.wide <= 1'b0;
              if (nxt_byte[SPI_RD_BIT]) begin
                state_ff   <= SPI_RD;
                req_ff.req <= 1'b1;
              end else begin
                state_ff <= SPI_WR;
              end
            end
            SPI_WR: begin
              req_ff.req   <= 1'b1;
              req_ff.we    <= 1'b1;
              req_ff.addr  <= REG_ADDR_W'(addr_ff);
              req_ff.wdata <= DATA_W'(nxt_byte);
              addr_ff      <= nxt_addr;
            end
            SPI_RD: begin
              req_ff.req  <= 1'b1;
              req_ff.we   <= 1'b0;
              req_ff.addr <= REG_ADDR_W'(nxt_addr);
              addr_ff     <= nxt_addr;
            end
            default: state_ff <= SPI_CMD;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // read data out, driven only in the read phase
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      rd_byte_ff  <= '0;
      sdo_ff      <= 1'b0;
      sdo_oe_n_ff <= OE_N_OFF;
    end else begin
      if (rdata_vld_i) begin
        rd_byte_ff <= rdata_i;
      end
      sdo_ff      <= rd_byte_ff[BIT_CNT_W'(SPI_BYTE_MSB) - bit_cnt_ff];
      sdo_oe_n_ff <= ~(active && state_ff == SPI_RD);
    end
  end

  assign req_o      = req_ff;
  assign sdo_o      = sdo_ff;
  assign sdo_oe_n_o = sdo_oe_n_ff;

endmodule : csel_spi_engine

// *** verification/csel_regs_model.sv ***
// register store standing behind the block's register request port
`timescale 1ns/1ns
module csel_regs_model
  import csel_pkg::*;
(
  input  wire logic             core_clk_i,
  input  wire csel_reg_req_type req_i,
  output logic [DATA_W-1:0]     rdata_o
);
  logic [DATA_W-1:0] mem_ff [256];
  initial rdata_o = 16'h0000;
  // outside the answer cycle the data toggles, so a late sample shows up
  always @(posedge core_clk_i) begin
    if (req_i.req && req_i.we) begin
      mem_ff[req_i.addr] <= req_i.wdata;
    end
    rdata_o <= (req_i.req && !req_i.we) ? mem_ff[req_i.addr]
                                        : ~rdata_o;
  end
endmodule : csel_regs_model

// *** verification/csel_checker.sv ***
// port assertions for the control interface select block
`timescale 1ns/1ns
module csel_checker
  import csel_pkg::*;
#(
  parameter int NPORT = 4,
  parameter int HW_W  = 16
)(
  input wire logic              core_clk_i,
  input wire logic              sys_rst_i,
  input wire logic [SEL_W-1:0]  interface_select_i,
  input wire logic              force_tristate_in_i,
  input wire csel_spi_pins_type spi_pins_i,
  input wire logic [HW_W-1:0]   hw_ctrl_i,
  input wire logic [HW_W-1:0]   hw_ctrl_o,
  input wire logic [NPORT-1:0]  port_los_i,
  input wire logic [NPORT-1:0]  port_loss_of_signal_out_o,
  input wire logic [NPORT-1:0]  port_los_oe_n_o,
  input wire logic [1:0]        par_data_oe_n_o,
  input wire logic              spi_sdo_oe_n_o,
  input wire csel_mode_type     mode_o,
  input wire csel_reg_req_type  reg_req_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  // pin synchronisers make the pin relations lag a few cycles; loss of signal is not synchronised and lags one
  a_force_float: assert property (
    force_tristate_in_i [*5] |-> &{par_data_oe_n_o, spi_sdo_oe_n_o,
    port_los_oe_n_o}) else $error("outputs not floated");
  a_los_follow: assert property (
    !$past(sys_rst_i) |-> port_loss_of_signal_out_o == $past(port_los_i))
    else $error("loss of signal pin wrong");
  a_hw_quiet: assert property (
    mode_o == IFM_HW |-> par_data_oe_n_o == 2'h3 && spi_sdo_oe_n_o &&
    !reg_req_o.req) else $error("host pins active in hw mode");
  a_hw_copy: assert property (
    (interface_select_i[2:1] == SEL_HW && $stable(hw_ctrl_i)) [*6] |->
    hw_ctrl_o == hw_ctrl_i) else $error("hw control not passed");
  a_hw_zero: assert property (
    (mode_o != IFM_HW) [*2] |-> hw_ctrl_o == '0)
    else $error("hw control leaks");
  a_par8_hi: assert property (
    mode_o == IFM_PAR8 |-> par_data_oe_n_o[1]) else $error("upper byte on");
  a_spi_par: assert property (
    mode_o == IFM_SPI |-> par_data_oe_n_o == 2'h3) else $error("bus driven");
  a_par_spi: assert property (
    mode_o inside {IFM_PAR8, IFM_PAR16} |-> spi_sdo_oe_n_o)
    else $error("serial out driven");
  a_mode_dec: assert property (
    $stable(interface_select_i) [*6] |->
    mode_o == csel_mode_type'(interface_select_i[2:1])) else $error("mode");
  a_sdo_idle: assert property (
    spi_pins_i.cs_n [*5] |-> spi_sdo_oe_n_o) else $error("serial out idle");
  a_req_width: assert property (
    reg_req_o.req |-> reg_req_o.wide == (mode_o == IFM_PAR16) &&
    (reg_req_o.wide || !reg_req_o.we || reg_req_o.wdata[15:8] == 8'h00))
    else $error("request width wrong");
  c_wr: cover property (reg_req_o.req && reg_req_o.we);
  c_rd_wide: cover property (reg_req_o.req && !reg_req_o.we && reg_req_o.wide);
  c_sdo: cover property (!spi_sdo_oe_n_o);
  c_force: cover property (force_tristate_in_i && mode_o != IFM_HW);
endmodule : csel_checker
bind csel_top csel_checker #(.NPORT(NPORT), .HW_W(HW_W)) csel_checker_i (
  .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
  .interface_select_i(interface_select_i),
  .force_tristate_in_i(force_tristate_in_i), .spi_pins_i(spi_pins_i),
  .hw_ctrl_i(hw_ctrl_i), .hw_ctrl_o(hw_ctrl_o), .port_los_i(port_los_i),
  .port_loss_of_signal_out_o(port_loss_of_signal_out_o),
  .port_los_oe_n_o(port_los_oe_n_o), .par_data_oe_n_o(par_data_oe_n_o),
  .spi_sdo_oe_n_o(spi_sdo_oe_n_o), .mode_o(mode_o), .reg_req_o(reg_req_o));

// *** verification/tb.sv ***
// self-checking bench for the control interface select block
`timescale 1ns/1ns
module tb;
  import csel_pkg::*;
  logic              clk = 1'b0, rst = 1'b1, frc = 1'b0, mux = 1'b0;
  logic              cpol = 1'b0, cpha = 1'b0;
  logic [2:0]        sel = 3'h0;
  logic [7:0]        paddr = 8'h00;
  logic [15:0]       hv = 16'h0000, hw_in = 16'h0000;
  logic [3:0]        los_in = 4'h0;
  csel_par_ctl_type  pctl = 6'h3e;
  csel_spi_pins_type spins = 3'h2;
  logic [15:0]       pdo, pdin, hw_out, rdata;
  logic [1:0]        poe_n;
  logic [3:0]        los_out, los_oe_n;
  logic              sdo, sdo_oe_n;
  csel_mode_type     mode;
  csel_reg_req_type  req;
  logic [31:0]       seed = 32'h794f;
  int                err_count = 0, tests_run = 0, cyc = 0;
  // an undriven serial line reads unknown so it can never match
  wire logic sdo_seen = sdo_oe_n ? 1'bx : sdo;
  assign pdin = {poe_n[1] ? hv[15:8] : pdo[15:8],
                 poe_n[0] ? hv[7:0] : pdo[7:0]};
  csel_top csel_top_i (
    .core_clk_i(clk), .sys_rst_i(rst), .interface_select_i(sel),
    .force_tristate_in_i(frc), .par_muxed_i(mux), .par_ctl_i(pctl),
    .par_addr_i(paddr), .par_data_i(pdin), .par_data_o(pdo),
    .par_data_oe_n_o(poe_n), .spi_pins_i(spins), .spi_cpol_i(cpol),
    .spi_cpha_i(cpha), .spi_sdo_o(sdo), .spi_sdo_oe_n_o(sdo_oe_n),
    .hw_ctrl_i(hw_in), .hw_ctrl_o(hw_out), .port_los_i(los_in),
    .port_loss_of_signal_out_o(los_out), .port_los_oe_n_o(los_oe_n),
    .mode_o(mode), .reg_req_o(req), .reg_rdata_i(rdata));
  csel_regs_model csel_regs_model_i (.core_clk_i(clk), .req_i(req),
    .rdata_o(rdata));
  initial forever #10 clk = ~clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // the upper byte only counts on the 16-bit bus
  function automatic logic [15:0] exp_word(input logic [15:0] v,
                                           input logic w);
    return w ? v : {8'h00, v[7:0]};
  endfunction : exp_word
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // select and strap change only while reset is held
  task automatic start(input logic [2:0] s, input logic m);
    rst = 1'b1;
    sel = s;
    mux = m;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    chk(16'(mode), {14'h0000, s[2:1]});
  endtask : start
  // the unused style's strobes are held active to prove they are ignored
  task automatic par_acc(input logic wr, input logic [7:0] a,
                         input logic [15:0] d, output logic [15:0] q);
    if (mux) begin
      hv = {8'h00, a};
      pctl.ale = 1'b1;
      repeat (3) @(negedge clk);
      pctl.ale = 1'b0;
    end
    paddr = mux ? ~a : a;
    hv = wr ? d : 16'(rnd());
    @(negedge clk);
    pctl = sel[0] ? {3'b000, !wr, 2'b00} : {1'b0, wr, !wr, seed[0], 2'b00};
    repeat (10) @(negedge clk);
    q = pdin;
    pctl = 6'h3e;
    repeat (6) @(negedge clk);
  endtask : par_acc
  task automatic hw_test();
    logic [15:0] q;
    repeat (3) begin
      hw_in = 16'(rnd());
      los_in = 4'(rnd());
      par_acc(1'b1, 8'h11, hw_in, q);
      chk(hw_out, hw_in);
      chk({12'h000, los_out}, {12'h000, los_in});
    end
    frc = 1'b1;
    repeat (5) @(negedge clk);
    chk({12'h000, los_oe_n}, 16'h000f);
    frc = 1'b0;
  endtask : hw_test
  task automatic par_test(input logic w);
    logic [7:0]  a;
    logic [15:0] d, q, m;
    a = 8'(rnd());
    d = 16'(rnd());
    m = w ? 16'hffff : 16'h00ff;
    par_acc(1'b1, a, d, q);
    par_acc(1'b1, a + 8'h01, ~d, q);
    par_acc(1'b0, a, d, q);
    chk(q & m, exp_word(d, w));
    par_acc(1'b0, a + 8'h01, d, q);
    chk(q & m, exp_word(~d, w));
    chk(hw_out, 16'h0000);
    // a forced read leaves the bus at the host's own levels
    frc = 1'b1;
    par_acc(1'b0, a, d, q);
    chk(q, hv);
    frc = 1'b0;
  endtask : par_test
  // 10 cycles a bit keeps the serial rate at half the top rate
  task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      if (!cpha) spins.sdi = tx[i];
      repeat (5) @(negedge clk);
      if (!cpha) rx[i] = sdo_seen;
      spins.sclk = ~cpol;
      if (cpha) spins.sdi = tx[i];
      repeat (5) @(negedge clk);
      if (cpha) rx[i] = sdo_seen;
      spins.sclk = cpol;
    end
    repeat (12) @(negedge clk);
  endtask : spi_byte
  task automatic spi_frame(input logic [23:0] tx, output logic [15:0] rx);
    logic [7:0] r;
    spins.cs_n = 1'b0;
    for (int b = 2; b >= 0; b--) begin
      spi_byte(tx[b*8+:8], r);
      rx = {rx[7:0], r};
    end
    spins.cs_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask : spi_frame
  task automatic spi_test();
    logic [7:0]  a;
    logic [15:0] d, q;
    for (int c = 0; c < 4; c++) begin
      {cpol, cpha} = 2'(c);
      spins = {cpol, 2'b10};
      @(negedge clk);
      a = 8'(rnd());
      d = 16'(rnd());
      spi_frame({1'b0, a[6:0], d}, q);
      spi_frame({1'b1, a[6:0], 16'h0000}, q);
      chk(q, d);
    end
  endtask : spi_test
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    for (int s = 0; s < 8; s++) begin
      start(3'(s), s[0] ^ s[1]);
      case (s[2:1])
        2'h0: hw_test();
        2'h1: spi_test();
        default: par_test(s[1]);
      endcase
      $display("select %0d done", s);
    end
    give_verdict();
  end
endmodule : tb
